// >>> design/tcs_pkg.sv
// Package of offsets, field positions and carriers for the timer channel regs
package tcs_pkg;

   localparam int TCS_AW = 8;
   localparam int TCS_DW = 32;
   localparam int TCS_VW = 16;
   localparam int TCS_NEV = 8;

   // Register byte addresses
   localparam logic [7:0] TCS_OFF_COUNTER = 8'h10;
   localparam logic [7:0] TCS_OFF_CCA = 8'h14;
   localparam logic [7:0] TCS_OFF_CCB = 8'h18;
   localparam logic [7:0] TCS_OFF_PCC = 8'h1C;
   localparam logic [7:0] TCS_OFF_STATUS = 8'h20;
   localparam logic [7:0] TCS_OFF_IRQ_EN = 8'h24;
   localparam logic [7:0] TCS_OFF_IRQ_DIS = 8'h28;
   localparam logic [7:0] TCS_OFF_IRQ_MASK = 8'h2C;

   // Status field positions
   localparam int TCS_BIT_OVERFLOW = 0;
   localparam int TCS_BIT_LOAD_OVERRUN = 1;
   localparam int TCS_BIT_COMPARE_A = 2;
   localparam int TCS_BIT_COMPARE_B = 3;
   localparam int TCS_BIT_COMPARE_C = 4;
   localparam int TCS_BIT_LOAD_A = 5;
   localparam int TCS_BIT_LOAD_B = 6;
   localparam int TCS_BIT_EXT_TRIGGER = 7;
   localparam int TCS_BIT_CLK_STATUS = 16;
   localparam int TCS_BIT_LINE_A = 17;
   localparam int TCS_BIT_LINE_B = 18;

   // Reset values
   localparam logic [15:0] TCS_RST_VALUE = 16'h0000;
   localparam logic [7:0] TCS_RST_FLAGS = 8'h00;
   localparam logic [31:0] TCS_RST_RDATA = 32'h0000_0000;

   // Mode select: 0 capture, 1 waveform
   localparam logic TCS_MODE_CAPTURE = 1'b0;
   localparam logic TCS_MODE_WAVE = 1'b1;

   // Event flags, bit 7 down to bit 0
   typedef struct packed {
      logic ext_trigger;
      logic load_b;
      logic load_a;
      logic compare_c;
      logic compare_b;
      logic compare_a;
      logic load_overrun;
      logic overflow;
   } tcs_events_t;

   // Strobes and levels from the channel's counter and waveform logic
   typedef struct packed {
      logic overflow;
      logic compare_a;
      logic compare_b;
      logic compare_c;
      logic load_a;
      logic load_b;
      logic ext_trigger;
      logic clock_enabled;
      logic line_a_pin;
      logic line_b_pin;
      logic line_a_drive;
      logic line_b_drive;
   } tcs_chan_t;

endpackage

// >>> design/tcs_sticky_flags.sv
// Sticky event flags, cleared by a clear pulse, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module tcs_sticky_flags
   import tcs_pkg::*;
#(
   parameter int W = TCS_NEV
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Control
   input wire logic [W-1:0] set_in,
   input wire logic clear_in,
   // State
   output logic [W-1:0] flags_out
);
   if (W < 1) begin : g_chk
      $error("tcs_sticky_flags: W must be at least 1");
   end

   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   always_comb begin
      flags_d = set_in | (flags_q & ~{W{clear_in}});
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_out = flags_q;
endmodule // tcs_sticky_flags
`default_nettype wire

// >>> design/tcs_irq_mask.sv
// Interrupt mask set by enable writes and cleared by disable writes
`timescale 1ns/1ps
`default_nettype none
module tcs_irq_mask
   import tcs_pkg::*;
#(
   parameter int W = TCS_NEV
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Write side
   input wire logic enable_wr_in,
   input wire logic disable_wr_in,
   input wire logic [W-1:0] data_in,
   // State
   output logic [W-1:0] mask_out
);
   if (W < 1) begin : g_chk
      $error("tcs_irq_mask: W must be at least 1");
   end

   logic [W-1:0] mask_q;
   logic [W-1:0] mask_d;

   always_comb begin
      mask_d = mask_q;
      if (enable_wr_in) begin
         mask_d = mask_d | data_in;
      end
      if (disable_wr_in) begin
         mask_d = mask_d & ~data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mask_q <= '0;
      end else begin
         mask_q <= mask_d;
      end
   end

   assign mask_out = mask_q;
endmodule // tcs_irq_mask
`default_nettype wire

// >>> design/tcs_channel_regs.sv
// Register view, status flags and interrupt of one timer channel
// How it works
// RQ1: Mode bit 0 selects capture, 1 selects waveform operation.
// RQ2: Register A is read-only in capture, read-write in waveform.
// RQ3: Counter value register returns the live 16-bit counter.
// RQ4: Register A reads return current contents, captures shown at once.
// RQ5: Register B is 16 bits, written only in waveform, always readable.
// RQ6: Period register C is 16 bits, read-write in both modes.
// RQ7: Event flags are sticky and cleared only by reading status or by reset.
// RQ8: Overflow sets status bit 0 in either mode.
// RQ9: Capture only: A or B loaded twice unread sets bit 1.
// RQ10: Waveform only: A match sets bit 2, B match bit 3.
// RQ11: Register C match sets bit 4 in either mode.
// RQ12: Capture only: A load sets bit 5, B load bit 6.
// RQ13: External trigger sets status bit 7.
// RQ14: Status bit 16 shows counter clock enabled, not an event.
// RQ15: Bits 17, 18 mirror lines: pin in capture, drive in waveform.
// RQ16: Writing 1 to enable register bits 0-7 sets mask bits.
// RQ17: Writing 1 to disable register bits 0-7 clears mask bits.
// RQ18: Mask register reads back the eight enabled interrupts.
// RQ19: Interrupt high while any flag is set with its mask bit.
// RQ20: Reset clears flags and mask; unused bits read zero.
`timescale 1ns/1ps
`default_nettype none
module tcs_channel_regs
   import tcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   // Register port
   input wire logic [TCS_AW-1:0] addr_in,
   input wire logic [TCS_DW-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [TCS_DW-1:0] rd_data_out,
   // Channel logic side
   input wire logic wave_mode_in,
   input wire logic [TCS_VW-1:0] counter_value_in,
   input wire logic [TCS_VW-1:0] capture_value_in,
   input wire tcs_chan_t chan_in,
   output logic [TCS_VW-1:0] capture_compare_a_out,
   output logic [TCS_VW-1:0] capture_compare_b_out,
   output logic [TCS_VW-1:0] period_compare_c_out,
   // Interrupt
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic wr_cca;
   logic wr_ccb;
   logic wr_pcc;
   logic wr_ien;
   logic wr_idis;
   logic rd_cca;
   logic rd_ccb;
   logic rd_status;
   logic capture_mode;

   // RQ1: mode bit split
   assign capture_mode = (wave_mode_in == TCS_MODE_CAPTURE);

   always_comb begin
      wr_cca = wr_en_in && (addr_in == TCS_OFF_CCA);
      wr_ccb = wr_en_in && (addr_in == TCS_OFF_CCB);
      wr_pcc = wr_en_in && (addr_in == TCS_OFF_PCC);
      wr_ien = wr_en_in && (addr_in == TCS_OFF_IRQ_EN);
      wr_idis = wr_en_in && (addr_in == TCS_OFF_IRQ_DIS);
      rd_cca = rd_en_in && (addr_in == TCS_OFF_CCA);
      rd_ccb = rd_en_in && (addr_in == TCS_OFF_CCB);
      rd_status = rd_en_in && (addr_in == TCS_OFF_STATUS);
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture/compare and period registers

   logic [TCS_VW-1:0] cca_q;
   logic [TCS_VW-1:0] cca_d;
   logic [TCS_VW-1:0] ccb_q;
   logic [TCS_VW-1:0] ccb_d;
   logic [TCS_VW-1:0] pcc_q;
   logic [TCS_VW-1:0] pcc_d;
   logic load_a;
   logic load_b;

   // Hardware loads only count in capture operation
   assign load_a = capture_mode && chan_in.load_a;
   assign load_b = capture_mode && chan_in.load_b;

   always_comb begin
      cca_d = cca_q;
      ccb_d = ccb_q;
      pcc_d = pcc_q;
      // RQ2: A writable in waveform only
      if (load_a) begin
         cca_d = capture_value_in;
      end else if (wr_cca && !capture_mode) begin
         cca_d = wr_data_in[TCS_VW-1:0];
      end
      // RQ5: B writes ignored in capture
      if (load_b) begin
         ccb_d = capture_value_in;
      end else if (wr_ccb && !capture_mode) begin
         ccb_d = wr_data_in[TCS_VW-1:0];
      end
      // RQ6: C writable in both modes
      if (wr_pcc) begin
         pcc_d = wr_data_in[TCS_VW-1:0];
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cca_q <= TCS_RST_VALUE;
         ccb_q <= TCS_RST_VALUE;
         pcc_q <= TCS_RST_VALUE;
      end else begin
         cca_q <= cca_d;
         ccb_q <= ccb_d;
         pcc_q <= pcc_d;
      end
   end

   assign capture_compare_a_out = cca_q;
   assign capture_compare_b_out = ccb_q;
   assign period_compare_c_out = pcc_q;

   ////////////////////////////////////////////////////////////////////////
   // Load overrun tracking

   // A load leaves the register unread until software reads it
   logic unread_a_q;
   logic unread_a_d;
   logic unread_b_q;
   logic unread_b_d;
   logic overrun;

   always_comb begin
      // RQ9: second load while unread
      overrun = (load_a && unread_a_q) || (load_b && unread_b_q);
      // A load in the same cycle as the read keeps the register unread
      unread_a_d = load_a || (unread_a_q && !rd_cca);
      unread_b_d = load_b || (unread_b_q && !rd_ccb);
      if (!capture_mode) begin
         unread_a_d = 1'b0;
         unread_b_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         unread_a_q <= 1'b0;
         unread_b_q <= 1'b0;
      end else begin
         unread_a_q <= unread_a_d;
         unread_b_q <= unread_b_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky status flags and mask

   tcs_events_t ev_set;
   tcs_events_t flags;
   tcs_events_t flags_view;
   logic [TCS_NEV-1:0] mask;

   always_comb begin
      // RQ8: overflow in both modes
      ev_set.overflow = chan_in.overflow;
      ev_set.load_overrun = overrun;
      // RQ10: compare A and B in waveform only
      ev_set.compare_a = !capture_mode && chan_in.compare_a;
      ev_set.compare_b = !capture_mode && chan_in.compare_b;
      // RQ11: compare C in both modes
      ev_set.compare_c = chan_in.compare_c;
      // RQ12: load flags in capture only
      ev_set.load_a = load_a;
      ev_set.load_b = load_b;
      // RQ13: external trigger
      ev_set.ext_trigger = chan_in.ext_trigger;
   end

   // RQ7: sticky, cleared by status read
   tcs_sticky_flags #(
      .W(TCS_NEV)
   ) u_flags (
      .clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .set_in(ev_set),
      .clear_in(rd_status),
      .flags_out(flags)
   );

   // RQ16: enable writes set mask bits
   // RQ17: disable writes clear mask bits
   tcs_irq_mask #(
      .W(TCS_NEV)
   ) u_mask (
      .clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .enable_wr_in(wr_ien),
      .disable_wr_in(wr_idis),
      .data_in(wr_data_in[TCS_NEV-1:0]),
      .mask_out(mask)
   );

   // Mode-gated flags read 0 after a mode change too
   always_comb begin
      flags_view = flags;
      if (capture_mode) begin
         flags_view.compare_a = 1'b0;
         flags_view.compare_b = 1'b0;
      end else begin
         flags_view.load_overrun = 1'b0;
         flags_view.load_a = 1'b0;
         flags_view.load_b = 1'b0;
      end
   end

   // RQ19: level interrupt from flags and mask
   assign irq_out = |(flags_view & mask);

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [TCS_DW-1:0] rd_q;
   logic [TCS_DW-1:0] rd_d;
   logic [TCS_DW-1:0] status_word;

   always_comb begin
      // RQ20: unused bits zero
      status_word = '0;
      status_word[TCS_NEV-1:0] = flags_view;
      // RQ14: clock enabled level
      status_word[TCS_BIT_CLK_STATUS] = chan_in.clock_enabled;
      // RQ15: line mirrors follow mode
      status_word[TCS_BIT_LINE_A] = capture_mode ? chan_in.line_a_pin
                                                 : chan_in.line_a_drive;
      status_word[TCS_BIT_LINE_B] = capture_mode ? chan_in.line_b_pin
                                                 : chan_in.line_b_drive;
   end

   always_comb begin
      rd_d = '0;
      if (rd_en_in) begin
         unique case (addr_in)
            // RQ3: live counter
            TCS_OFF_COUNTER: rd_d[TCS_VW-1:0] = counter_value_in;
            // RQ4: current register A
            TCS_OFF_CCA: rd_d[TCS_VW-1:0] = cca_q;
            TCS_OFF_CCB: rd_d[TCS_VW-1:0] = ccb_q;
            TCS_OFF_PCC: rd_d[TCS_VW-1:0] = pcc_q;
            TCS_OFF_STATUS: rd_d = status_word;
            // RQ18: mask readback
            TCS_OFF_IRQ_MASK: rd_d[TCS_NEV-1:0] = mask;
            // Write-only and unmapped addresses read zero
            default: rd_d = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_q <= TCS_RST_RDATA;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign rd_data_out = rd_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   // RQ7: flag set by event seen on next status read
   a_status_sticky: assert property (@(posedge core_clk_in) // RQ7
      disable iff (!arst_n_in)
      (chan_in.overflow && !rd_status) ##1 rd_status
      |=> rd_data_out[TCS_BIT_OVERFLOW])
      else $error("overflow flag lost before status read");

   // RQ7: status read clears flags when no new event
   a_read_clears: assert property (@(posedge core_clk_in) // RQ7
      disable iff (!arst_n_in)
      (rd_status && ev_set == '0) |=> (flags == '0))
      else $error("status read did not clear flags");

   // RQ9: second unread load raises overrun
   a_overrun_set: assert property (@(posedge core_clk_in) // RQ9
      disable iff (!arst_n_in)
      (capture_mode && chan_in.load_a && !rd_status) ##1
      (capture_mode && chan_in.load_a && !rd_cca && !rd_status)
      ##1 (capture_mode && !rd_status) |-> flags.load_overrun)
      else $error("double load without read gave no overrun");

   // RQ10: compare flags stay 0 in capture view
   a_cmp_capture: assert property (@(posedge core_clk_in) // RQ10
      disable iff (!arst_n_in)
      (rd_status && capture_mode) |=> (rd_data_out[3:2] == 2'b00))
      else $error("compare A/B flag read 1 in capture operation");

   // RQ12: waveform reads show no load flags
   a_load_wave: assert property (@(posedge core_clk_in) // RQ12
      disable iff (!arst_n_in)
      (rd_status && !capture_mode) |=> (rd_data_out[6:5] == 2'b00
      && !rd_data_out[TCS_BIT_LOAD_OVERRUN]))
      else $error("load flag read 1 in waveform operation");

   // RQ5: capture-mode write to B leaves it unchanged
   a_ccb_locked: assert property (@(posedge core_clk_in) // RQ5
      disable iff (!arst_n_in)
      (wr_ccb && capture_mode && !chan_in.load_b)
      |=> $stable(ccb_q))
      else $error("register B changed by write in capture operation");

   // RQ6: C written in any mode reads back
   a_pcc_rw: assert property (@(posedge core_clk_in) // RQ6
      disable iff (!arst_n_in)
      wr_pcc ##1 (rd_en_in && addr_in == TCS_OFF_PCC && !wr_pcc)
      |=> (rd_data_out == {16'h0000, $past(wr_data_in[15:0], 2)}))
      else $error("register C readback mismatch");

   // RQ16: enable write sets the written mask bits
   a_mask_enable: assert property (@(posedge core_clk_in) // RQ16
      disable iff (!arst_n_in)
      (wr_ien && !wr_idis) |=> ((mask & $past(wr_data_in[7:0]))
      == $past(wr_data_in[7:0])))
      else $error("enable write did not set mask bits");

   // RQ17: disable clears mask bits
   a_mask_disable: assert property (@(posedge core_clk_in) // RQ17
      disable iff (!arst_n_in)
      wr_idis |=> ((mask & $past(wr_data_in[7:0])) == 8'h00))
      else $error("disable write did not clear mask bits");

   // RQ19: interrupt drops after a clean status read
   a_irq_clear: assert property (@(posedge core_clk_in) // RQ19
      disable iff (!arst_n_in)
      (rd_status && ev_set == '0) |=> !irq_out)
      else $error("interrupt still high after status read");

   // RQ3: counter read returns value of the strobe cycle
   a_counter_live: assert property (@(posedge core_clk_in) // RQ3
      disable iff (!arst_n_in)
      (rd_en_in && addr_in == TCS_OFF_COUNTER)
      |=> (rd_data_out == {16'h0000, $past(counter_value_in)}))
      else $error("counter value read mismatch");

endmodule // tcs_channel_regs
`default_nettype wire

// >>> testbench/tb_tcs_channel_regs.sv
// Self-checking bench for the timer channel register view
`timescale 1ns/1ps
`default_nettype none
module tb_tcs_channel_regs;
   import tcs_pkg::*;

   // Event bits kept in each mode
   localparam logic [7:0] CAP_OK = 8'hF3;
   localparam logic [7:0] WAVE_OK = 8'h9D;

   logic core_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [TCS_AW-1:0] addr = '0;
   logic [TCS_DW-1:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic wave = 1'b0;
   logic [TCS_VW-1:0] cnt = '0;
   logic [TCS_VW-1:0] cap = '0;
   logic [6:0] stb = '0;
   logic [4:0] lvl = '0;
   tcs_chan_t chan;
   logic [TCS_DW-1:0] rd_data;
   logic [TCS_VW-1:0] reg_a;
   logic [TCS_VW-1:0] reg_b;
   logic [TCS_VW-1:0] reg_c;
   logic irq;
   logic [15:0] ea = '0;
   logic [15:0] eb = '0;
   logic [15:0] ec = '0;
   logic [7:0] flags = '0;
   logic [7:0] mask = '0;
   logic [31:0] r;
   int errors = 0;
   int checks = 0;
   int wb[5] = '{0, 2, 3, 4, 7};

   assign chan = {stb, lvl};

   always #50 core_clk_in = ~core_clk_in;

   tcs_channel_regs DUT (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .addr_in(addr),
      .wr_data_in(wdata),
      .wr_en_in(wr_en),
      .rd_en_in(rd_en),
      .rd_data_out(rd_data),
      .wave_mode_in(wave),
      .counter_value_in(cnt),
      .capture_value_in(cap),
      .chan_in(chan),
      .capture_compare_a_out(reg_a),
      .capture_compare_b_out(reg_b),
      .period_compare_c_out(reg_c),
      .irq_out(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk_in);
      wr_en <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input string what);
      @(posedge core_clk_in);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge core_clk_in);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp, what);
   endtask

   function automatic logic [31:0] st_exp(input logic [7:0] f);
      logic [7:0] g;
      g = f & (wave ? WAVE_OK : CAP_OK);
      st_exp = {13'h0, wave ? chan.line_b_drive : chan.line_b_pin,
                wave ? chan.line_a_drive : chan.line_a_pin,
                chan.clock_enabled, 8'h00, g};
   endfunction

   // One strobe on status bit b; levels change with it
   task automatic ev(input int b);
      logic [6:0] s;
      s = '0;
      s[b == 0 ? 6 : 7 - b] = 1'b1;
      @(posedge core_clk_in);
      stb <= s;
      lvl <= 5'($urandom);
      @(posedge core_clk_in);
      stb <= '0;
      flags[b] = flags[b] | (wave ? WAVE_OK[b] : CAP_OK[b]);
      if (!wave && b == 5) ea = cap;
      if (!wave && b == 6) eb = cap;
   endtask

   task automatic rd_status;
      rd(TCS_OFF_STATUS, st_exp(flags), "status");
      flags = '0;
   endtask

   task automatic regs_chk;
      rd(TCS_OFF_CCA, {16'h0, ea}, "reg a"); // A read back
      rd(TCS_OFF_CCB, {16'h0, eb}, "reg b"); // B read back
      rd(TCS_OFF_PCC, {16'h0, ec}, "reg c"); // C read back
      chk({reg_a, reg_b}, {ea, eb}, "reg a b outs"); // outputs
      chk({16'h0, reg_c}, {16'h0, ec}, "reg c out"); // output
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk_in);
      errors++;
      print_verdict();
   end

   initial begin
      void'($urandom(52868));
      repeat (20) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      regs_chk(); // registers zero
      rd(TCS_OFF_IRQ_MASK, 32'h0000_0000, "mask rst"); // mask zero
      rd_status(); // flags zero
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         @(posedge core_clk_in);
         cnt <= r[15:0];
         rd(TCS_OFF_COUNTER, {16'h0, r[15:0]}, "counter"); // live count
      end
      @(posedge core_clk_in);
      wave <= 1'b1;
      r = 32'hFFFF_FFFF;
      wr(TCS_OFF_CCA, r); // A writable
      ea = r[15:0];
      r = $urandom;
      wr(TCS_OFF_CCB, r); // B writable
      eb = r[15:0];
      r = $urandom;
      wr(TCS_OFF_PCC, r); // C writable
      ec = r[15:0];
      regs_chk();
      @(posedge core_clk_in);
      wave <= 1'b0;
      wr(TCS_OFF_CCA, $urandom); // A refused
      wr(TCS_OFF_CCB, $urandom); // B refused
      r = $urandom;
      // Write C and read it back with no gap
      @(posedge core_clk_in);
      wr_en <= 1'b1;
      addr <= TCS_OFF_PCC;
      wdata <= r;
      @(posedge core_clk_in);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge core_clk_in);
      rd_en <= 1'b0;
      ec = r[15:0];
      #1 chk(rd_data, {16'h0, ec}, "c back to back"); // C writable
      regs_chk();
      @(posedge core_clk_in);
      cap <= 16'h1234;
      ev(5); // load a
      rd(TCS_OFF_CCA, {16'h0, ea}, "a load"); // capture shown
      ev(6); // load b
      @(posedge core_clk_in);
      cap <= 16'hBEEF;
      ev(6); // second unread load
      flags[1] = 1'b1;
      rd_status(); // overrun set
      rd_status(); // cleared by read
      rd(TCS_OFF_CCB, {16'h0, eb}, "b load"); // B holds last
      ev(5);
      rd(TCS_OFF_CCA, {16'h0, ea}, "a again");
      ev(5); // read between loads
      rd_status(); // no overrun
      // Two loads of A in consecutive cycles
      @(posedge core_clk_in);
      cap <= 16'h5A5A;
      stb <= 7'h04;
      repeat (2) @(posedge core_clk_in);
      stb <= '0;
      ea = 16'h5A5A;
      flags[5] = 1'b1;
      flags[1] = 1'b1;
      rd_status(); // back-to-back loads overrun
      rd(TCS_OFF_CCA, {16'h0, ea}, "a last");
      for (int m = 0; m < 2; m++) begin
         @(posedge core_clk_in);
         wave <= m[0];
         for (int b = 0; b < 8; b++) begin
            if (b != 1) begin
               ev(b); // mode gating
               rd_status(); // levels shown
            end
         end
      end
      for (int k = 0; k < 24; k++) begin
         r = $urandom;
         wr(TCS_OFF_IRQ_EN, r); // enable sets
         mask = mask | r[7:0];
         if (k % 3 == 0) begin
            r = $urandom;
            wr(TCS_OFF_IRQ_DIS, r); // disable clears
            mask = mask & ~r[7:0];
         end
         rd(TCS_OFF_IRQ_MASK, {24'h0, mask}, "mask"); // mask read
         ev(wb[$urandom % 5]); // random event
         #1 chk(irq, |(flags & mask), "irq set"); // irq follows
         rd_status();
         chk(irq, 1'b0, "irq clr"); // cleared by read
      end
      wr(TCS_OFF_IRQ_MASK, 32'hFFFF_FFFF); // read-only mask
      wr(8'h30, 32'hFFFF_FFFF);
      rd(TCS_OFF_IRQ_MASK, {24'h0, mask}, "mask ro"); // unchanged
      rd(TCS_OFF_IRQ_EN, 32'h0000_0000, "en wo"); // reads zero
      rd(TCS_OFF_IRQ_DIS, 32'h0000_0000, "dis wo"); // reads zero
      rd(8'h30, 32'h0000_0000, "unmapped"); // reads zero
      // Event just before and during a status read: set beats clear
      @(posedge core_clk_in);
      stb <= 7'h40;
      @(posedge core_clk_in);
      rd_en <= 1'b1;
      addr <= TCS_OFF_STATUS;
      @(posedge core_clk_in);
      stb <= '0;
      rd_en <= 1'b0;
      #1 chk(rd_data, st_exp(8'h01), "event then read"); // flag seen
      flags = 8'h01;
      rd_status(); // read-cycle event kept
      // Second reset in mid-run
      ev(0);
      @(posedge core_clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      flags = '0;
      mask = '0;
      {ea, eb, ec} = '0;
      #1 chk(irq, 1'b0, "irq rst"); // irq low
      regs_chk(); // registers zero
      rd(TCS_OFF_IRQ_MASK, 32'h0000_0000, "mask rst2"); // mask zero
      rd_status(); // flags zero
      print_verdict();
   end

endmodule // tb_tcs_channel_regs
`default_nettype wire
